// ===== rtl/clock_monitor_and_source_select.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "clock_supervisor_map.svh"
`default_nettype none
module clock_monitor_and_source_select #(
  parameter clock_supervisor_pkg::count_t MEAS_REF_EDGES = `CSM_MEAS_REF_EDGES
) (
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_b_i,
  input  wire clock_supervisor_pkg::bus_req_s bus_i,
  output logic [31:0]                         rdata_o,
  output logic                                irq_o,
  input  wire logic                           pll_lock_i,
  input  wire logic                           fast_internal_rc_clock_clk_i,
  input  wire logic                           fast_external_oscillator_clk_i,
  input  wire logic                           pll_clk_i,
  input  wire clock_supervisor_pkg::fault_s   fault_ack_i,
  output clock_supervisor_pkg::fault_s        fault_o,
  output logic                                crystal_oscillator_enable_o,
  output logic                                pll_enable_o,
  output logic                                pll_ref_select_o,
  output logic [2:0]                          sysclk_src_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Saturating increment, so a runaway clock cannot wrap a count
  function automatic clock_supervisor_pkg::count_t sat_inc(
    input clock_supervisor_pkg::count_t c,
    input logic                         en
  );
    sat_inc = c;
    if (en && (c != 16'hffff))
    begin
      sat_inc = c + 16'h0001;
    end
  endfunction

  // ****************************************************************
  // State declarations
  // ****************************************************************
  logic [3:0]                       ctrl;          // Clock control bits
  logic [3:0]                       next_ctrl;
  logic                             mon_en;        // Supervision enabled
  logic                             next_mon_en;
  logic [7:0]                       rc_div;        // Reference divider
  logic [7:0]                       next_rc_div;
  clock_supervisor_pkg::count_t     high_bound;    // PLL upper bound
  clock_supervisor_pkg::count_t     next_high_bound;
  clock_supervisor_pkg::count_t     low_bound;     // PLL lower bound
  clock_supervisor_pkg::count_t     next_low_bound;
  logic [5:0]                       status;        // Sticky events
  logic [5:0]                       next_status;
  logic [5:0]                       mask;          // Interrupt mask
  logic [5:0]                       next_mask;
  logic [31:0]                      next_rdata;
  logic                             next_irq;
  logic [2:0]                       next_src;
  clock_supervisor_pkg::fault_s     next_fault;

  // Edge history of the sampled clocks and lock
  logic                             fast_internal_rc_clock_prev;
  logic                             fast_external_oscillator_prev;
  logic                             pll_prev;
  logic                             lock_prev;
  logic                             fast_internal_rc_clock_rise;
  logic                             fast_external_oscillator_rise;
  logic                             pll_rise;

  // Supervision window
  clock_supervisor_pkg::mon_state_e mon_state;
  clock_supervisor_pkg::mon_state_e next_mon_state;
  logic [7:0]                       div_cnt;       // RC edges in window
  logic [7:0]                       next_div_cnt;
  clock_supervisor_pkg::count_t     fx_cnt;        // Oscillator edges
  clock_supervisor_pkg::count_t     next_fx_cnt;
  clock_supervisor_pkg::count_t     pll_cnt;       // PLL edges
  clock_supervisor_pkg::count_t     next_pll_cnt;
  clock_supervisor_pkg::fault_s     events;        // Faults this cycle

  // Frequency measurement
  clock_supervisor_pkg::meas_state_e meas_state;
  clock_supervisor_pkg::meas_state_e next_meas_state;
  clock_supervisor_pkg::count_t     meas_rc;       // RC edges counted
  clock_supervisor_pkg::count_t     next_meas_rc;
  clock_supervisor_pkg::count_t     meas_ref;      // Oscillator edges
  clock_supervisor_pkg::count_t     next_meas_ref;
  clock_supervisor_pkg::count_t     meas_result;   // Last result
  clock_supervisor_pkg::count_t     next_meas_result;
  logic                             meas_done;     // Completion pulse

  // Write strobes decoded once
  logic                             wr_mon;

  assign fast_internal_rc_clock_rise  = fast_internal_rc_clock_clk_i & ~fast_internal_rc_clock_prev;
  assign fast_external_oscillator_rise = fast_external_oscillator_clk_i & ~fast_external_oscillator_prev;
  assign pll_rise   = pll_clk_i & ~pll_prev;
  assign wr_mon     = bus_i.we && (bus_i.addr == `CSM_OFF_MON);

  // ****************************************************************
  // Supervision window, paced by internal RC edges only
  // ****************************************************************

  // Counts oscillator and PLL edges over one divided RC period
  always_comb
  begin
    logic [7:0]                   div_eff;
    clock_supervisor_pkg::count_t fx_now;
    clock_supervisor_pkg::count_t pll_now;
    div_eff        = (rc_div == 8'h00) ? 8'h01 : rc_div;
    fx_now         = sat_inc(fx_cnt, fast_external_oscillator_rise);
    pll_now        = sat_inc(pll_cnt, pll_rise);
    next_mon_state = mon_state;
    next_div_cnt   = div_cnt;
    next_fx_cnt    = fx_now;
    next_pll_cnt   = pll_now;
    events         = '0;
    // Loss of lock only counts while the PLL is meant to run
    events.loss_of_lock = ctrl[`CSM_CTRL_PLL_EN] & lock_prev & ~pll_lock_i;
    unique case (mon_state)
      clock_supervisor_pkg::MON_OFF:
      begin
        // Nothing but loss of lock is judged until software arms the monitor
        next_div_cnt = 8'h00;
        next_fx_cnt  = '0;
        next_pll_cnt = '0;
        if (mon_en)
        begin
          next_mon_state = clock_supervisor_pkg::MON_RUN;
        end
      end
      clock_supervisor_pkg::MON_RUN:
      begin
        if (!mon_en)
        begin
          next_mon_state = clock_supervisor_pkg::MON_OFF;
        end
        else if (fast_internal_rc_clock_rise)
        begin
          if ((div_cnt + 8'h01) >= div_eff)
          begin
            // Window over: judge and restart
            next_div_cnt      = 8'h00;
            next_fx_cnt       = '0;
            next_pll_cnt      = '0;
            events.fast_external_oscillator_loss = (fx_now == '0);
            if (ctrl[`CSM_CTRL_PLL_EN])
            begin
              // A silent PLL is a loss, not merely too slow
              events.pll_loss = (pll_now == '0);
              events.pll_high = (pll_now > high_bound);
              events.pll_low  = (pll_now != '0) && (pll_now < low_bound);
            end
          end
          else
          begin
            next_div_cnt = div_cnt + 8'h01;
          end
        end
      end
    endcase
  end

  // Registers the window state and edge history
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mon_state  <= clock_supervisor_pkg::MON_OFF;
      div_cnt    <= 8'h00;
      fx_cnt     <= '0;
      pll_cnt    <= '0;
      fast_internal_rc_clock_prev  <= 1'b0;
      fast_external_oscillator_prev <= 1'b0;
      pll_prev   <= 1'b0;
      lock_prev  <= 1'b0;
    end
    else
    begin
      mon_state  <= next_mon_state;
      div_cnt    <= next_div_cnt;
      fx_cnt     <= next_fx_cnt;
      pll_cnt    <= next_pll_cnt;
      fast_internal_rc_clock_prev  <= fast_internal_rc_clock_clk_i;
      fast_external_oscillator_prev <= fast_external_oscillator_clk_i;
      pll_prev   <= pll_clk_i;
      lock_prev  <= pll_lock_i;
    end
  end

  // ****************************************************************
  // Frequency measurement of the internal RC clock
  // ****************************************************************

  // Counts RC edges over a fixed number of oscillator edges
  always_comb
  begin
    next_meas_state  = meas_state;
    next_meas_rc     = sat_inc(meas_rc, fast_internal_rc_clock_rise);
    next_meas_ref    = sat_inc(meas_ref, fast_external_oscillator_rise);
    next_meas_result = meas_result;
    meas_done        = 1'b0;
    unique case (meas_state)
      clock_supervisor_pkg::MEAS_IDLE:
      begin
        next_meas_rc  = '0;
        next_meas_ref = '0;
        if (wr_mon && bus_i.wdata[`CSM_MON_START])
        begin
          next_meas_state = clock_supervisor_pkg::MEAS_RUN;
        end
      end
      clock_supervisor_pkg::MEAS_RUN:
      begin
        // A dead oscillator leaves this state running; software times it
        if (next_meas_ref >= MEAS_REF_EDGES)
        begin
          next_meas_state  = clock_supervisor_pkg::MEAS_IDLE;
          next_meas_result = next_meas_rc;
          meas_done        = 1'b1;
        end
      end
    endcase
  end

  // Registers the measurement
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meas_state  <= clock_supervisor_pkg::MEAS_IDLE;
      meas_rc     <= '0;
      meas_ref    <= '0;
      meas_result <= '0;
    end
    else
    begin
      meas_state  <= next_meas_state;
      meas_rc     <= next_meas_rc;
      meas_ref    <= next_meas_ref;
      meas_result <= next_meas_result;
    end
  end

  // ****************************************************************
  // Software registers, interrupt, faults and clock source
  // ****************************************************************

  // Register writes, read mux, sticky status and fault holding
  always_comb
  begin
    logic [5:0] ev;
    ev              = {meas_done, events};
    next_ctrl       = ctrl;
    next_mon_en     = mon_en;
    next_rc_div     = rc_div;
    next_high_bound = high_bound;
    next_low_bound  = low_bound;
    next_mask       = mask;
    next_status     = status;
    next_rdata      = 32'h0000_0000;
    if (bus_i.we)
    begin
      unique case (bus_i.addr)
        `CSM_OFF_CTRL:   next_ctrl       = bus_i.wdata[3:0];
        `CSM_OFF_MON:
        begin
          next_mon_en = bus_i.wdata[`CSM_MON_EN];
          next_rc_div = bus_i.wdata[`CSM_MON_DIV_MSB:`CSM_MON_DIV_LSB];
        end
        `CSM_OFF_HIGH:   next_high_bound = bus_i.wdata[15:0];
        `CSM_OFF_LOW:    next_low_bound  = bus_i.wdata[15:0];
        `CSM_OFF_MASK:   next_mask       = bus_i.wdata[5:0];
        default:         next_ctrl       = ctrl;
      endcase
    end
    if (bus_i.re)
    begin
      unique case (bus_i.addr)
        `CSM_OFF_CTRL:   next_rdata = {28'h0000000, ctrl};
        `CSM_OFF_MON:    next_rdata = {16'h0000, rc_div, 6'h00,
                                       (meas_state == clock_supervisor_pkg::MEAS_RUN),
                                       mon_en};
        `CSM_OFF_HIGH:   next_rdata = {16'h0000, high_bound};
        `CSM_OFF_LOW:    next_rdata = {16'h0000, low_bound};
        `CSM_OFF_MEAS:   next_rdata = {16'h0000, meas_result};
        `CSM_OFF_STATUS:
        begin
          next_rdata  = {26'h0000000, status};
          next_status = 6'h00;
        end
        `CSM_OFF_MASK:   next_rdata = {26'h0000000, mask};
        `CSM_OFF_SYS:    next_rdata = {26'h0000000, ctrl[`CSM_CTRL_CRYSTAL_OSCILLATOR_EN], pll_lock_i,
                                       1'b0, sysclk_src_o};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
    // New events win over the clearing read
    next_status = next_status | ev;
    next_irq    = |(next_status & next_mask);
    // Fault stays up until the collector acknowledges it
    next_fault  = (fault_o & ~fault_ack_i) | events;
    // PLL drives the system only while locked and requested
    if (ctrl[`CSM_CTRL_SYS_PLL] && ctrl[`CSM_CTRL_PLL_EN] && pll_lock_i)
    begin
      next_src = `CSM_SRC_PLL;
    end
    else
    begin
      next_src = `CSM_SRC_FAST_INTERNAL_RC_CLOCK;
    end
  end

  // Registers software state and every output
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl             <= `CSM_RST_CTRL;
      mon_en           <= 1'b0;
      rc_div           <= `CSM_RST_DIV;
      high_bound       <= `CSM_RST_HIGH;
      low_bound        <= `CSM_RST_LOW;
      status           <= 6'h00;
      mask             <= 6'h00;
      rdata_o          <= 32'h0000_0000;
      irq_o            <= 1'b0;
      fault_o          <= '0;
      sysclk_src_o     <= `CSM_SRC_FAST_INTERNAL_RC_CLOCK;
      crystal_oscillator_enable_o    <= 1'b0;
      pll_enable_o     <= 1'b0;
      pll_ref_select_o <= 1'b0;
    end
    else
    begin
      ctrl             <= next_ctrl;
      mon_en           <= next_mon_en;
      rc_div           <= next_rc_div;
      high_bound       <= next_high_bound;
      low_bound        <= next_low_bound;
      status           <= next_status;
      mask             <= next_mask;
      rdata_o          <= next_rdata;
      irq_o            <= next_irq;
      fault_o          <= next_fault;
      sysclk_src_o     <= next_src;
      crystal_oscillator_enable_o    <= next_ctrl[`CSM_CTRL_CRYSTAL_OSCILLATOR_EN];
      pll_enable_o     <= next_ctrl[`CSM_CTRL_PLL_EN];
      pll_ref_select_o <= next_ctrl[`CSM_CTRL_REF_SEL];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/clock_supervisor_map.svh
`ifndef CLOCK_SUPERVISOR_MAP_SVH
`define CLOCK_SUPERVISOR_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CSM_OFF_CTRL        8'h00
`define CSM_OFF_MON         8'h04
`define CSM_OFF_HIGH        8'h08
`define CSM_OFF_LOW         8'h0c
`define CSM_OFF_MEAS        8'h10
`define CSM_OFF_STATUS      8'h14
`define CSM_OFF_MASK        8'h18
`define CSM_OFF_SYS         8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define CSM_CTRL_CRYSTAL_OSCILLATOR_EN    0
`define CSM_CTRL_PLL_EN     1
`define CSM_CTRL_REF_SEL    2
`define CSM_CTRL_SYS_PLL    3
`define CSM_MON_EN          0
`define CSM_MON_START       1
`define CSM_MON_DIV_LSB     8
`define CSM_MON_DIV_MSB     15
`define CSM_ST_MEAS_DONE    5
`define CSM_SYS_LOCK        4
`define CSM_SYS_CRYSTAL_OSCILLATOR        5

// ****************************************************************
// Reset values, codes and counts
// ****************************************************************
`define CSM_RST_CTRL        4'h0
`define CSM_RST_DIV         8'h01
`define CSM_RST_HIGH        16'hffff
`define CSM_RST_LOW         16'h0000
`define CSM_SRC_FAST_INTERNAL_RC_CLOCK        3'h0
`define CSM_SRC_PLL         3'h2
`define CSM_MEAS_REF_EDGES  16'h0100
`endif

// ===== rtl/clock_supervisor_pkg.sv
`default_nettype none
package clock_supervisor_pkg;
  // Counter width for all edge counts except the 8-bit window divider count
  typedef logic [15:0] count_t;

  // Faults towards the fault collection unit, bit 4 first
  typedef struct packed {
    logic pll_loss;
    logic pll_low;
    logic pll_high;
    logic fast_external_oscillator_loss;
    logic loss_of_lock;
  } fault_s;

  // One register access from software
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } bus_req_s;

  // Supervision window state
  typedef enum logic {MON_OFF, MON_RUN} mon_state_e;

  // Frequency measurement state
  typedef enum logic {MEAS_IDLE, MEAS_RUN} meas_state_e;
endpackage
`default_nettype wire

// ===== testbench/clock_supervisor_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "clock_supervisor_map.svh"
// ****************************************************************
// Port-level properties of the clock supervisor
// ****************************************************************
module clock_supervisor_checker #(
  parameter clock_supervisor_pkg::count_t MEAS_REF_EDGES = 16'h0100
) (
  input wire logic                           sys_clk_i,
  input wire logic                           rst_b_i,
  input wire clock_supervisor_pkg::bus_req_s bus_i,
  input wire logic                           pll_lock_i,
  input wire clock_supervisor_pkg::fault_s   fault_ack_i,
  input wire clock_supervisor_pkg::fault_s   fault_o,
  input wire logic                           crystal_oscillator_enable_o,
  input wire logic                           pll_enable_o,
  input wire logic                           pll_ref_select_o,
  input wire logic [2:0]                     sysclk_src_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Decoded control writes
  wire             ctrl_wr = bus_i.we && bus_i.addr == `CSM_OFF_CTRL;
  wire             mon_wr  = bus_i.we && bus_i.addr == `CSM_OFF_MON;
  // Faults raised and not yet acknowledged
  wire logic [4:0] held    = fault_o & ~fault_ack_i;
  logic            mon_en_q;
  logic            next_mon_en;
  // Shadow of the monitor enable, kept apart from the design's copy
  always_comb next_mon_en = mon_wr ? bus_i.wdata[0] : mon_en_q;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i) mon_en_q <= 1'b0;
    else mon_en_q <= next_mon_en;
  // Lock seen, then lost while the PLL is on
  sequence s_lock_drop;
    pll_enable_o && pll_lock_i ##1 pll_enable_o && !pll_lock_i;
  endsequence
  property p_ctrl_copy;
    ctrl_wr |=> {pll_ref_select_o, pll_enable_o, crystal_oscillator_enable_o} == $past(bus_i.wdata[2:0]);
  endproperty
  a_ctrl_copy: assert property (p_ctrl_copy) else $error("ctrl outputs miss write");
  property p_ctrl_hold;
    !ctrl_wr |=> $stable({pll_ref_select_o, pll_enable_o, crystal_oscillator_enable_o});
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl outputs moved");
  property p_src_pll;
    sysclk_src_o == `CSM_SRC_PLL |-> $past(pll_enable_o && pll_lock_i);
  endproperty
  a_src_pll: assert property (p_src_pll) else $error("PLL source without lock");
  property p_src_fast_internal_rc_clock;
    !$past(pll_lock_i) |-> sysclk_src_o == `CSM_SRC_FAST_INTERNAL_RC_CLOCK;
  endproperty
  a_src_fast_internal_rc_clock: assert property (p_src_fast_internal_rc_clock) else $error("no RC fallback");
  property p_lol;
    s_lock_drop |-> ##[1:2] fault_o.loss_of_lock;
  endproperty
  a_lol: assert property (p_lol) else $error("loss of lock not reported");
  property p_hold;
    (|held) |=> ((fault_o & $past(held)) == $past(held));
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped before ack");
  property p_mon_gate;
    $rose(fault_o.fast_external_oscillator_loss) |-> $past(mon_en_q) || $past(mon_en_q, 2);
  endproperty
  a_mon_gate: assert property (p_mon_gate) else $error("fault while monitor off");
  property p_pll_gate;
    $rose(|held[4:2]) |-> $past(pll_enable_o) || $past(pll_enable_o, 2);
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("PLL fault with PLL off");
endmodule
bind clock_monitor_and_source_select clock_supervisor_checker #(
  .MEAS_REF_EDGES(MEAS_REF_EDGES)
) u_clock_supervisor_checker (.sys_clk_i, .rst_b_i, .bus_i, .pll_lock_i, .fault_ack_i,
  .fault_o, .crystal_oscillator_enable_o, .pll_enable_o, .pll_ref_select_o, .sysclk_src_o);
`default_nettype wire

// ===== testbench/fault_unit_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Fault collection unit: acknowledges held faults
// ****************************************************************
module fault_unit_model (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         handle_i,
  input  wire logic                         slow_i,
  input  wire clock_supervisor_pkg::fault_s fault_i,
  output clock_supervisor_pkg::fault_s      ack_o
);
  int cnt [5]; // Cycles each fault has been seen
  // One-cycle ack after a short or a long wait; slow wait tests the hold
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ack_o <= '0;
      cnt   <= '{default: 0};
    end
    else
      for (int i = 0; i < 5; i++)
      begin
        ack_o[i] <= fault_i[i] && handle_i && !ack_o[i] && cnt[i] >= (slow_i ? 6 : 1);
        cnt[i]   <= (fault_i[i] && !ack_o[i]) ? cnt[i] + 1 : 0;
      end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Self-checking bench with a register model
// ****************************************************************
module tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, lock = 1'b0, handle = 1'b0, slow = 1'b0;
  logic fast_internal_rc_clock = 1'b0, fast_external_oscillator = 1'b0, pllc = 1'b0, fx_run = 1'b1, pll_run = 1'b1;
  logic crystal_oscillator_en, pll_en, ref_sel, irq;
  logic [2:0]  src;
  logic [31:0] rdata, d, v;
  clock_supervisor_pkg::bus_req_s bus = '0;
  clock_supervisor_pkg::fault_s   fault, ack;
  int n_mismatch = 0, checked = 0, seed = 77, cyc = 0;
  int mreg [9]; // Expected register contents
  int wmask [9] = '{'hf, 'hff01, 'hffff, 'hffff, 0, 0, 'h3f, 0, 0};
  int waddr [8] = '{0, 8, 'hc, 'h18, 'h10, 'h14, 'h1c, 'h20};
  // en, fx run, pll run, high, low, expected status
  int cfg [5][6] = '{'{0, 0, 0, 'hffff, 0, 0}, '{1, 0, 1, 'hffff, 0, 2},
    '{1, 1, 0, 'hffff, 0, 'h10}, '{1, 1, 1, 2, 0, 4}, '{1, 1, 1, 'hffff, 100, 8}};
  always #2.5 sys_clk = ~sys_clk;
  // Sampled clock levels; the RC clock never stops
  always @(posedge sys_clk)
  begin
    fast_internal_rc_clock  <= ~fast_internal_rc_clock;
    fast_external_oscillator <= fx_run & ~fast_external_oscillator;
    pllc  <= pll_run & ~pllc;
  end
  clock_monitor_and_source_select #(.MEAS_REF_EDGES(16'h0004)) u_clock_monitor_and_source_select (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .bus_i(bus), .rdata_o(rdata), .irq_o(irq),
    .pll_lock_i(lock), .fast_internal_rc_clock_clk_i(fast_internal_rc_clock), .fast_external_oscillator_clk_i(fast_external_oscillator), .pll_clk_i(pllc),
    .fault_ack_i(ack), .fault_o(fault), .crystal_oscillator_enable_o(crystal_oscillator_en), .pll_enable_o(pll_en),
    .pll_ref_select_o(ref_sel), .sysclk_src_o(src));
  fault_unit_model u_fault_unit_model (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .handle_i(handle), .slow_i(slow), .fault_i(fault), .ack_o(ack));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write; the model keeps only writable bits
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    @(posedge sys_clk) bus <= {a, dd, 2'b10};
    @(posedge sys_clk) bus <= '0;
    mreg[a >> 2] = dd & wmask[a >> 2];
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] vv);
    @(posedge sys_clk) bus <= {a, 32'h0, 2'b01};
    @(posedge sys_clk) bus <= '0;
    #1 vv = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] vv;
    rd(a, vv);
    chk($sformatf("reg %h", a), vv, mreg[a >> 2]);
    if (a == 8'h14) mreg[5] = 0;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    mreg = '{0, 'h100, 'hffff, 0, 0, 0, 0, 0, 0};
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk("outs", {fault, crystal_oscillator_en, pll_en, ref_sel, src}, 0);
    for (int i = 0; i <= 32; i += 4) rd_chk(8'(i));
    $display("test reset done");
    // Random writes, read-only and unmapped places included
    foreach (waddr[i])
    begin
      d = $random(seed);
      wr(8'(waddr[i]), d);
      // Source status: oscillator enable echoed, lock low, RC source
      mreg[7] = (mreg[0] & 1) << 5;
      rd_chk(8'(waddr[i]));
    end
    chk("ctrl outs", {ref_sel, pll_en, crystal_oscillator_en}, mreg[0] & 7);
    $display("test regs done");
    @(posedge sys_clk) handle <= 1'b1;
    slow   <= 1'b1;
    lock   <= 1'b1;
    wr(8'h00, 32'hb);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge sys_clk);
    mreg[7] = 'h32;
    rd_chk(8'h1c);
    @(posedge sys_clk) lock <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("lol", {fault.loss_of_lock, irq, src}, 5'h18);
    mreg[5] = 1;
    rd_chk(8'h14);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq clear", irq, 0);
    repeat (8) @(posedge sys_clk);
    #1 chk("fault release", fault, 0);
    @(posedge sys_clk) lock <= 1'b1;
    slow <= 1'b0;
    wr(8'h00, 32'h2);
    $display("test lock done");
    // Monitor windows of four RC edges
    foreach (cfg[i])
    begin
      @(posedge sys_clk) fx_run <= 1'(cfg[i][1]);
      pll_run <= 1'(cfg[i][2]);
      wr(8'h08, cfg[i][3]);
      wr(8'h0c, cfg[i][4]);
      wr(8'h04, 32'h400 | cfg[i][0]);
      repeat (40) @(posedge sys_clk);
      wr(8'h04, 32'h400);
      repeat (4) @(posedge sys_clk);
      mreg[5] = cfg[i][5];
      rd_chk(8'h14);
    end
    $display("test monitor done");
    @(posedge sys_clk) fx_run <= 1'b1;
    wr(8'h04, 32'h402);
    mreg[1] = 'h402;
    rd_chk(8'h04);
    repeat (30) @(posedge sys_clk);
    mreg[1] = 'h400;
    rd_chk(8'h04);
    mreg[5] = 'h20;
    rd_chk(8'h14);
    rd(8'h10, v);
    // Equal rates: four oscillator edges span three or four RC edges
    chk("meas count", 32'(v >= 3 && v <= 4), 1);
    $display("test measure done");
    close_out();
  end
endmodule
`default_nettype wire
